//--- eoc_chk.sv
// Port checker for the datagram responder
`timescale 1ns/1ps
`default_nettype none
module eoc_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic cmd_error_o
);
  // One clock domain, reset disables all checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_len; $rose(tx_valid_o) |-> tx_data_o inside {8'h2C, 8'h08, 8'h14}; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_busy; rx_ready_o != tx_valid_o; endproperty
  a_busy: assert property (p_busy) else $error("ready clash");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
  a_hold: assert property (p_hold) else $error("octet lost");
  property p_ind;
    rx_valid_i && rx_ready_o && rx_data_i == 8'h04 ##1 rx_valid_i ##1 rx_data_i == 8'h01
      ##1 rx_valid_i && rx_last_i && rx_data_i == 8'h02 |=> tx_valid_o && tx_data_o == 8'h14;
  endproperty
  a_ind: assert property (p_ind) else $error("no answer");
  property p_resp; rx_valid_i && rx_ready_o && rx_last_i && rx_data_i[7] |=> !tx_valid_o;
  endproperty
  a_resp: assert property (p_resp) else $error("answered");
  property p_unsol; $rose(tx_valid_o) |-> $past(rx_valid_i && rx_ready_o && rx_last_i);
  endproperty
  a_unsol: assert property (p_unsol) else $error("unsolicited");
  property p_end; tx_valid_o && tx_last_o && tx_ready_i |=> rx_ready_o && !tx_last_o; endproperty
  a_end: assert property (p_end) else $error("no end");
  property p_err; $rose(cmd_error_o) |-> $past(rx_valid_i && rx_ready_o); endproperty
  a_err: assert property (p_err) else $error("stray error");
endmodule : eoc_chk
bind eoc_datagram_responder eoc_chk u_chk (.*);
`default_nettype wire

//--- eoc_co_model.sv
// Central-office controller model: sends commands, sinks responses
`timescale 1ns/1ps
`default_nettype none
module eoc_co_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic rdy_i,
  input wire logic [7:0] d_i,
  input wire logic v_i,
  input wire logic l_i,
  output logic [7:0] d_o,
  output logic v_o,
  output logic l_o,
  output logic r_o,
  output logic done_o
);
  logic [7:0] rsp [$];
  initial {d_o, v_o, l_o, r_o, done_o} = '0;
  // Sends one 4-octet command, each octet held until taken or until 50 waits pass
  task automatic send(input logic [31:0] d);
    int w;
    for (int i = 0; i < 4; i++) begin
      d_o <= d[31 - 8 * i -: 8];
      v_o <= 1'b1;
      l_o <= (i == 3);
      w = 0;
      // Ready is looked at while settled, then the octet is taken at the next edge
      @(negedge clk_i);
      while (!rdy_i && w < 50) begin
        @(negedge clk_i);
        w++;
      end
      @(posedge clk_i);
    end
    v_o <= 1'b0;
    l_o <= 1'b0;
    d_o <= ~d[7:0]; // Released line shows the inverse
  endtask : send
  // Collects octets; stalls every other cycle when slow
  always @(posedge clk_i) begin
    if (v_i && r_o) rsp.push_back(d_i);
    done_o <= v_i && r_o && l_i;
    r_o <= slow_i ? ~r_o : 1'b1;
  end
endmodule : eoc_co_model
`default_nettype wire

//--- eoc_datagram_responder.sv
// Operations channel datagram responder with receive counters
`timescale 1ns/1ps
`default_nettype none
module eoc_datagram_responder #(
  parameter logic [31:0] VENDOR_ID = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] VENDOR_VERSION = 32'h0000_0001, // Arbitrary value
  parameter logic [255:0] SERIAL_NUMBER = 256'h0 // Arbitrary value, first octet in top bits
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic [15:0] mean_quality_i,
  input wire logic [15:0] zero_db_quality_i,
  input wire logic fec_corrected_i,
  input wire logic hec_error_i,
  input wire logic fec_message_i,
  input wire logic tc_frame_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic rx_ready_o,
  output logic cmd_error_o
);
  eoc_pkg::eoc_state_t state, next_state;
  eoc_pkg::eoc_rsp_t rsp, next_rsp;
  logic [1:0] cidx, next_cidx;
  logic [7:0] clen, next_clen;
  logic [7:0] cver, next_cver;
  logic [7:0] tag, next_tag;
  logic [5:0] oidx, next_oidx;
  logic [5:0] olast, next_olast;
  logic [351:0] frame, next_frame;
  logic [31:0] cnt_fec, next_cnt_fec;
  logic [31:0] cnt_hec, next_cnt_hec;
  logic [31:0] cnt_msg, next_cnt_msg;
  logic [31:0] cnt_frm, next_cnt_frm;
  logic cmd_err, next_cmd_err;
  logic accept;
  logic [7:0] rx_id;

  // Handshake: input taken only while idle, output held until taken
  assign rx_ready_o = (state == eoc_pkg::EOC_ST_RX);
  assign accept = rx_valid_i && rx_ready_o;
  assign rx_id = rx_data_i;
  assign tx_valid_o = (state == eoc_pkg::EOC_ST_TX);
  assign tx_data_o = frame[351:344]; // Shift register, most significant octet first
  assign tx_last_o = tx_valid_o && (oidx == olast);
  assign cmd_error_o = cmd_err;

  // Counters wrap naturally at 32 bits; all cleared by reset
  always_comb begin
    next_cnt_fec = cnt_fec + (fec_corrected_i ? eoc_pkg::EOC_ONE32 : eoc_pkg::EOC_ZERO32);
    next_cnt_hec = cnt_hec + (hec_error_i ? eoc_pkg::EOC_ONE32 : eoc_pkg::EOC_ZERO32);
    next_cnt_msg = cnt_msg + (fec_message_i ? eoc_pkg::EOC_ONE32 : eoc_pkg::EOC_ZERO32);
    next_cnt_frm = cnt_frm + (tc_frame_i ? eoc_pkg::EOC_ONE32 : eoc_pkg::EOC_ZERO32);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_fec <= eoc_pkg::EOC_ZERO32;
      cnt_hec <= eoc_pkg::EOC_ZERO32;
      cnt_msg <= eoc_pkg::EOC_ZERO32;
      cnt_frm <= eoc_pkg::EOC_ZERO32;
    end else begin
      cnt_fec <= next_cnt_fec;
      cnt_hec <= next_cnt_hec;
      cnt_msg <= next_cnt_msg;
      cnt_frm <= next_cnt_frm;
    end
  end

  // Command parser and response builder
  always_comb begin
    next_state = state;
    next_rsp = rsp;
    next_cidx = cidx;
    next_clen = clen;
    next_cver = cver;
    next_tag = tag;
    next_oidx = oidx;
    next_olast = olast;
    next_frame = frame;
    next_cmd_err = cmd_err;
    unique case (state)
      eoc_pkg::EOC_ST_RX: begin
        if (accept) begin
          next_cidx = cidx + eoc_pkg::EOC_CIDX_ONE;
          unique case (cidx)
            2'h0: begin
              next_clen = rx_data_i;
              next_cmd_err = 1'b0;
            end
            2'h1: next_tag = rx_data_i;
            2'h2: next_cver = rx_data_i;
            default: begin
              next_cidx = eoc_pkg::EOC_CIDX_ZERO;
              next_oidx = eoc_pkg::EOC_IDX_ZERO;
              // Check framing responses and unknown IDs are dropped
              if (clen != eoc_pkg::EOC_LEN_CMD || cver != eoc_pkg::EOC_VERSION
                  || !rx_last_i || rx_id[7]) begin
                next_cmd_err = 1'b1;
              end else if (rx_id == eoc_pkg::EOC_ID_GET_INV) begin
                next_state = eoc_pkg::EOC_ST_TX;
                next_rsp = eoc_pkg::EOC_RSP_INV;
                next_olast = 6'(eoc_pkg::EOC_INV_OCTETS - 1);
                next_frame = {eoc_pkg::EOC_LEN_INV, tag, eoc_pkg::EOC_VERSION,
                              eoc_pkg::EOC_ID_INV, VENDOR_ID, VENDOR_VERSION,
                              SERIAL_NUMBER};
              end else if (rx_id == eoc_pkg::EOC_ID_GET_TEST) begin
                next_state = eoc_pkg::EOC_ST_TX;
                next_rsp = eoc_pkg::EOC_RSP_TEST;
                next_olast = 6'(eoc_pkg::EOC_TEST_OCTETS - 1);
                next_frame = {eoc_pkg::EOC_LEN_TEST, tag, eoc_pkg::EOC_VERSION,
                              eoc_pkg::EOC_ID_TEST, mean_quality_i,
                              zero_db_quality_i, 288'h0};
              end else if (rx_id == eoc_pkg::EOC_ID_GET_IND) begin
                // Multi-bit indicators only leave through this answer
                next_state = eoc_pkg::EOC_ST_TX;
                next_rsp = eoc_pkg::EOC_RSP_IND;
                next_olast = 6'(eoc_pkg::EOC_IND_OCTETS - 1);
                // All four counts captured in the same cycle
                next_frame = {eoc_pkg::EOC_LEN_IND, tag, eoc_pkg::EOC_VERSION,
                              eoc_pkg::EOC_ID_IND, cnt_fec, cnt_hec, cnt_msg,
                              cnt_frm, 192'h0};
              end else begin
                next_cmd_err = 1'b1;
              end
            end
          endcase
          // Short datagram ended early: restart parsing
          if (rx_last_i && cidx != 2'h3) begin
            next_cidx = eoc_pkg::EOC_CIDX_ZERO;
            next_cmd_err = 1'b1;
          end
        end
      end
      eoc_pkg::EOC_ST_TX: begin
        if (tx_ready_i) begin
          next_frame = {frame[343:0], eoc_pkg::EOC_ZERO8};
          next_oidx = oidx + eoc_pkg::EOC_IDX_ONE;
          if (oidx == olast) begin
            next_state = eoc_pkg::EOC_ST_RX;
            next_oidx = eoc_pkg::EOC_IDX_ZERO;
          end
        end
      end
      default: next_state = eoc_pkg::EOC_ST_RX;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= eoc_pkg::EOC_ST_RX;
      rsp <= eoc_pkg::EOC_RSP_INV;
      cidx <= eoc_pkg::EOC_CIDX_ZERO;
      clen <= eoc_pkg::EOC_ZERO8;
      cver <= eoc_pkg::EOC_ZERO8;
      tag <= eoc_pkg::EOC_ZERO8;
      oidx <= eoc_pkg::EOC_IDX_ZERO;
      olast <= eoc_pkg::EOC_IDX_ZERO;
      frame <= '0;
      cmd_err <= 1'b0;
    end else begin
      state <= next_state;
      rsp <= next_rsp;
      cidx <= next_cidx;
      clen <= next_clen;
      cver <= next_cver;
      tag <= next_tag;
      oidx <= next_oidx;
      olast <= next_olast;
      frame <= next_frame;
      cmd_err <= next_cmd_err;
    end
  end
endmodule : eoc_datagram_responder
`default_nettype wire

//--- eoc_pkg.sv
// Constants for the operations channel datagram responder
// Summary of operation
// - Indicator request answered by Indicators response
// - Single-bit indicators via overhead, multi-bit here
// - Inventory: 2C, tag, 01, 80, ID, version, serial
// - Inventory sent only for inventory command
// - Vendor identifier big-endian 32-bit unsigned
// - Serial number exactly 32 octets, vendor defined
// - Loop-test: 08, tag, 01, 81, two 16-bit fields
// - Loop-test sent only for test command
// - Mean quality 16-bit big-endian code
// - Zero-dB quality 16-bit big-endian code
// - Indicators: 14, tag, 01, 82, four counts
// - Indicators sent only for indicator request
// - Corrected-codeword counter 32-bit, wraps
// - Codeword and message counts sampled together
// - Header-error counter once per cell, wraps
// - Header-error and frame counts sampled together
// - Codeword message counter 32-bit, wraps
// - Transport frame counter 32-bit, wraps
// - Fixed cells per frame in frame mode
// - IDs below 80 commands, 80 and above responses
package eoc_pkg;
  localparam logic [7:0] EOC_LEN_CMD = 8'h04;
  localparam logic [7:0] EOC_VERSION = 8'h01;
  localparam logic [7:0] EOC_ID_GET_INV = 8'h00;
  localparam logic [7:0] EOC_ID_GET_TEST = 8'h01;
  localparam logic [7:0] EOC_ID_GET_IND = 8'h02;
  localparam logic [7:0] EOC_ID_INV = 8'h80;
  localparam logic [7:0] EOC_ID_TEST = 8'h81;
  localparam logic [7:0] EOC_ID_IND = 8'h82;
  localparam logic [7:0] EOC_LEN_INV = 8'h2C;
  localparam logic [7:0] EOC_LEN_TEST = 8'h08;
  localparam logic [7:0] EOC_LEN_IND = 8'h14;
  localparam logic [7:0] EOC_ZERO8 = 8'h00;
  localparam logic [31:0] EOC_ZERO32 = 32'h0000_0000;
  localparam logic [31:0] EOC_ONE32 = 32'h0000_0001;
  localparam int EOC_HDR_OCTETS = 4;
  localparam int EOC_SERIAL_OCTETS = 32;
  localparam int EOC_INV_OCTETS = 44;
  localparam int EOC_TEST_OCTETS = 8;
  localparam int EOC_IND_OCTETS = 20;
  localparam logic [5:0] EOC_IDX_ZERO = 6'h00;
  localparam logic [5:0] EOC_IDX_ONE = 6'h01;
  localparam int EOC_CMD_OCTETS = 4;
  localparam logic [1:0] EOC_CIDX_ZERO = 2'h0;
  localparam logic [1:0] EOC_CIDX_ONE = 2'h1;
  typedef enum logic [1:0] {
    EOC_RSP_INV,
    EOC_RSP_TEST,
    EOC_RSP_IND
  } eoc_rsp_t;
  typedef enum logic [1:0] {
    EOC_ST_RX,
    EOC_ST_TX
  } eoc_state_t;
endpackage : eoc_pkg

//--- tb.sv
// Self-checking testbench for the datagram responder
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] VID = 32'h1234_5678; // Arbitrary value
  localparam logic [31:0] VVER = 32'h9ABC_DEF0; // Arbitrary value
  localparam logic [255:0] SER = {8{32'h0F1E_2D3C}}; // Arbitrary value
  logic clk_i = 1'b0, arst_n_i = 1'b0, slow = 1'b0;
  logic rx_valid_i, rx_last_i, tx_valid_o, tx_last_o, tx_ready_i, rx_ready_o, cmd_error_o;
  logic fec_corrected_i = 1'b0, hec_error_i = 1'b0, fec_message_i = 1'b0, tc_frame_i = 1'b0;
  logic [7:0] rx_data_i, tx_data_o;
  logic [15:0] mean_quality_i = 16'h0000, zero_db_quality_i = 16'h0000;
  logic [31:0] seed = 32'h29052172;
  logic [31:0] cnt [4] = '{default: 32'h0};
  logic [31:0] snap [4] = '{default: 32'h0};
  int n_mismatch = 0, num_checks = 0;
  eoc_datagram_responder #(.VENDOR_ID(VID), .VENDOR_VERSION(VVER), .SERIAL_NUMBER(SER)) uut (.*);
  eoc_co_model co (.clk_i(clk_i), .slow_i(slow), .rdy_i(rx_ready_o), .d_i(tx_data_o),
    .v_i(tx_valid_o), .l_i(tx_last_o), .d_o(rx_data_i), .v_o(rx_valid_i), .l_o(rx_last_i),
    .r_o(tx_ready_i), .done_o());
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected response octet i for command id
  function automatic logic [7:0] exp_oct(input logic [7:0] id, tg, input int i);
    logic [351:0] v;
    if (id == 8'h00) v = {8'h2C, tg, 8'h01, 8'h80, VID, VVER, SER};
    else if (id == 8'h01) v = {8'h08, tg, 8'h01, 8'h81, mean_quality_i, zero_db_quality_i, 288'h0};
    else v = {8'h14, tg, 8'h01, 8'h82, snap[0], snap[1], snap[2], snap[3], 192'h0};
    return v[351 - 8 * i -: 8];
  endfunction : exp_oct
  task automatic chk(input string s, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Random event pulses and the bench's own counters
  always @(posedge clk_i) begin
    if (arst_n_i) begin
      if (rx_valid_i && rx_ready_o && rx_last_i && rx_data_i == 8'h02) snap = cnt;
      cnt[0] += 32'(fec_corrected_i);
      cnt[1] += 32'(hec_error_i);
      cnt[2] += 32'(fec_message_i);
      cnt[3] += 32'(tc_frame_i);
    end
    {fec_corrected_i, hec_error_i, fec_message_i, tc_frame_i} <= 4'(xs());
  end
  // One command and the check of what comes back
  task automatic cmd(input logic [7:0] ver, id);
    int w;
    logic [7:0] tg;
    tg = 8'(xs());
    w = 0;
    co.rsp.delete();
    co.send({8'h04, tg, ver, id});
    // Done stands for one whole cycle, so it is looked at mid-cycle
    while (co.done_o !== 1'b1 && w < 300) begin
      @(negedge clk_i);
      w++;
    end
    @(posedge clk_i);
    if (ver != 8'h01 || id[7]) begin
      chk("error flag", 8'h01, 8'(cmd_error_o));
      chk("octet count", 8'h00, 8'(co.rsp.size()));
    end else if (w == 300) begin
      n_mismatch++;
      $display("unexpected response wait expected %h seen %h", 8'h01, 8'h00);
    end else begin
      chk("octet count", exp_oct(id, tg, 0), 8'(co.rsp.size()));
      foreach (co.rsp[i]) chk("octet", exp_oct(id, tg, i), co.rsp[i]);
    end
    $display("test id %h done", id);
  endtask : cmd
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      slow = k[0];
      mean_quality_i <= 16'(xs());
      zero_db_quality_i <= 16'(xs());
      cmd(8'h01, 8'(k % 3));
    end
    cmd(8'h02, 8'h02);
    cmd(8'h01, 8'h85);
    cmd(8'h01, 8'h02);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
